/* core/fpu_decode_pkg.sv */
/*
  Constants and enumerations for the floating-point format and function decoder.
  Assumes 32-bit instruction words with format in bits 25..21 and function in bits 5..0.
*/
package fpu_decode_pkg;
  localparam int unsigned INSN_W     = 32;
  localparam int unsigned FMT_HI     = 25;
  localparam int unsigned FMT_LO     = 21;
  localparam int unsigned FUNC_HI    = 5;
  localparam int unsigned FUNC_LO    = 0;
  localparam int unsigned TF_BIT     = 16;
  localparam int unsigned OPC_HI     = 31;
  localparam int unsigned OPC_LO     = 26;

  localparam logic [5:0] OPC_COP1    = 6'h11;
  localparam logic [5:0] OPC_COP2    = 6'h12;
  localparam logic [5:0] OPC_EXT     = 6'h13;

  localparam logic [4:0] FMT_IFACE_MAX = 5'h0F;
  localparam logic [4:0] FMT_SINGLE  = 5'h10;
  localparam logic [4:0] FMT_DOUBLE  = 5'h11;
  localparam logic [4:0] FMT_WORD    = 5'h14;
  localparam logic [4:0] FMT_LONG    = 5'h15;
  localparam logic [4:0] FMT_PAIRED  = 5'h16;

  localparam logic [2:0] ROW_COND_MOVE = 3'h2;
  localparam logic [2:0] ROW_CVT_UPPER = 3'h4;
  localparam logic [2:0] ROW_CVT_LOWER = 3'h5;

  typedef enum logic [3:0] {
    FC_IFACE    = 4'h0,
    FC_SINGLE   = 4'h1,
    FC_DOUBLE   = 4'h2,
    FC_WORD     = 4'h3,
    FC_LONG     = 4'h4,
    FC_PAIRED   = 4'h5,
    FC_RESERVED = 4'h6
  } fmt_class_t;

  typedef enum logic [4:0] {
    OP_NONE        = 5'h00,
    OP_ADD         = 5'h01,
    OP_SUB         = 5'h02,
    OP_MUL         = 5'h03,
    OP_DIV         = 5'h04,
    OP_SQRT        = 5'h05,
    OP_ABS         = 5'h06,
    OP_MOV         = 5'h07,
    OP_NEG         = 5'h08,
    OP_MOVE_IF_F   = 5'h09,
    OP_MOVE_IF_T   = 5'h0A,
    OP_CVT_UPPER   = 5'h0B,
    OP_CVT_LOWER   = 5'h0C,
    OP_COMPARE     = 5'h0D,
    OP_IDX_LOAD_W  = 5'h0E,
    OP_IDX_STORE_W = 5'h0F,
    OP_FMADD_S     = 5'h10,
    OP_FMSUB_S     = 5'h11,
    OP_NFMADD_S    = 5'h12,
    OP_NFMSUB_S    = 5'h13,
    OP_MF_FPR      = 5'h14,
    OP_DMF_FPR     = 5'h15,
    OP_MF_FPCTL    = 5'h16,
    OP_MF_FPR_HI   = 5'h17,
    OP_MT_FPR      = 5'h18,
    OP_DMT_FPR     = 5'h19,
    OP_MT_FPCTL    = 5'h1A,
    OP_MT_FPR_HI   = 5'h1B,
    OP_MF_COP2     = 5'h1C,
    OP_COP2_BRANCH = 5'h1D,
    OP_OTHER       = 5'h1E
  } fp_op_t;
endpackage

/* core/fpu_format_function_decoder.sv */
/*
  Decoder for floating-point coprocessor instructions: format class, operation,
  and reserved-instruction indication, registered once on the core clock.
  Assumes one instruction word presented per cycle with a valid strobe.
*/
// Notes on behaviour
// (RQ1) Format 0..15 means interface move/control, never a data format.
// (RQ2) Format 16 is single, 17 is double.
// (RQ3) Format 20 word, 21 long, 22 paired-single.
// (RQ4) Formats 18, 19, 23, 24..31 reserved; 24..31 unusable in three-bit format.
// (RQ5) Single/double/word/long function 0..7: add, sub, mul, div, sqrt, abs, mov, neg.
// (RQ6) Long format legal only with 64-bit float operation enabled.
// (RQ7) Paired-single legal only with 64-bit float operation enabled.
// (RQ8) Extension group legal only with 64-bit float operation enabled.
// (RQ9) Conditional move: bit 16 zero is move-if-false, one is move-if-true.
// (RQ10) Extension row 000 indexed load word, row 001 indexed store word.
// (RQ11) Extension rows 100..111 fused ops; rows 010, 011 reserved.
// (RQ12) Paired rows 100, 101 convert halves; rows 110, 111 compares.
// (RQ13) Coprocessor-2 rs row 00 move-from, row 01 condition branch.
// (RQ14) Interface low rs bits select the eight move/control operations.
// (RQ15) Reserved encodings or disabled 64-bit groups raise reserved indication.
`timescale 1ns/1ns
`default_nettype none
module fpu_format_function_decoder (
  input  wire logic                                clk,          // Core clock
  input  wire logic                                reset_n,      // Async reset, active low
  input  wire logic                                insn_valid,   // Instruction word present
  input  wire logic [fpu_decode_pkg::INSN_W-1:0]   insn,         // Instruction word
  input  wire logic                                fp64_enable,  // 64-bit float ops enabled
  output logic                                     dec_valid_q,  // Decode result valid
  output fpu_decode_pkg::fmt_class_t               fmt_class_q,  // Format class
  output fpu_decode_pkg::fp_op_t                   fp_op_q,      // Decoded operation
  output logic                                     reserved_q    // Reserved instruction
);
  // ---------------------------------------------------------------
  // Field extraction
  // ---------------------------------------------------------------
  wire logic [5:0] opc   = insn[fpu_decode_pkg::OPC_HI:fpu_decode_pkg::OPC_LO];
  wire logic [4:0] fmt   = insn[fpu_decode_pkg::FMT_HI:fpu_decode_pkg::FMT_LO];
  wire logic [5:0] func  = insn[fpu_decode_pkg::FUNC_HI:fpu_decode_pkg::FUNC_LO];
  wire logic [2:0] row   = func[5:3];
  wire logic [2:0] col   = func[2:0];
  wire logic       true_false_select_bit = insn[fpu_decode_pkg::TF_BIT];
  wire logic       is_cop1 = (opc == fpu_decode_pkg::OPC_COP1);
  wire logic       is_cop2 = (opc == fpu_decode_pkg::OPC_COP2);
  wire logic       fp_extension_group = (opc == fpu_decode_pkg::OPC_EXT);

  // ---------------------------------------------------------------
  // Format classification
  // ---------------------------------------------------------------
  function automatic fpu_decode_pkg::fmt_class_t classify(input logic [4:0] f);
    if (f <= fpu_decode_pkg::FMT_IFACE_MAX)
      return fpu_decode_pkg::FC_IFACE; // RQ1
    unique case (f)
      fpu_decode_pkg::FMT_SINGLE: return fpu_decode_pkg::FC_SINGLE; // RQ2
      fpu_decode_pkg::FMT_DOUBLE: return fpu_decode_pkg::FC_DOUBLE; // RQ2
      fpu_decode_pkg::FMT_WORD:   return fpu_decode_pkg::FC_WORD;   // RQ3
      fpu_decode_pkg::FMT_LONG:   return fpu_decode_pkg::FC_LONG;   // RQ3
      fpu_decode_pkg::FMT_PAIRED: return fpu_decode_pkg::FC_PAIRED; // RQ3
      default:                    return fpu_decode_pkg::FC_RESERVED; // RQ4
    endcase
  endfunction

  // Basic arithmetic row shared by the data formats, paired-single row 000 included
  function automatic fpu_decode_pkg::fp_op_t arith_op(input logic [2:0] c);
    fpu_decode_pkg::fp_op_t o;
    o = fpu_decode_pkg::fp_op_t'(5'(c) + 5'(fpu_decode_pkg::OP_ADD)); // RQ5
    return o;
  endfunction

  wire fpu_decode_pkg::fmt_class_t fclass = classify(fmt);
  wire logic fmt_arith = (fclass == fpu_decode_pkg::FC_SINGLE) ||
                         (fclass == fpu_decode_pkg::FC_DOUBLE) ||
                         (fclass == fpu_decode_pkg::FC_WORD) ||
                         (fclass == fpu_decode_pkg::FC_LONG) ||
                         (fclass == fpu_decode_pkg::FC_PAIRED);
  wire logic fmt_cmov = (fclass == fpu_decode_pkg::FC_SINGLE) ||
                        (fclass == fpu_decode_pkg::FC_DOUBLE) ||
                        (fclass == fpu_decode_pkg::FC_PAIRED);
  wire logic cmov_hit = fmt_cmov && (row == fpu_decode_pkg::ROW_COND_MOVE) &&
                        (col == 3'h1);
  wire logic row_zero = (row == 3'h0);
  wire logic [2:0] low_rs = fmt[2:0];
  wire logic [1:0] high_rs = fmt[4:3];

  // ---------------------------------------------------------------
  // Operation selection
  // ---------------------------------------------------------------
  fpu_decode_pkg::fp_op_t op_d;
  logic                   rsv_d;
  always_comb
  begin
    op_d  = fpu_decode_pkg::OP_NONE;
    rsv_d = 1'b0;
    if (is_cop1)
    begin
      if (fclass == fpu_decode_pkg::FC_IFACE)
      begin
        // Only rs row 00 holds the move group here; other interface rows pass on
        op_d = (high_rs == 2'h0) ?
               fpu_decode_pkg::fp_op_t'(5'(low_rs) + 5'(fpu_decode_pkg::OP_MF_FPR)) // RQ14
               : fpu_decode_pkg::OP_OTHER;
      end
      else if (fclass == fpu_decode_pkg::FC_RESERVED)
        rsv_d = 1'b1; // RQ15
      else if (cmov_hit)
        op_d = true_false_select_bit ? fpu_decode_pkg::OP_MOVE_IF_T
                                     : fpu_decode_pkg::OP_MOVE_IF_F; // RQ9
      else if (fmt_arith && row_zero)
        op_d = arith_op(col); // RQ5
      else if (fclass == fpu_decode_pkg::FC_PAIRED && row == fpu_decode_pkg::ROW_CVT_UPPER
               && col == 3'h0)
        op_d = fpu_decode_pkg::OP_CVT_UPPER; // RQ12
      else if (fclass == fpu_decode_pkg::FC_PAIRED && row == fpu_decode_pkg::ROW_CVT_LOWER
               && col == 3'h0)
        op_d = fpu_decode_pkg::OP_CVT_LOWER; // RQ12
      else if (row[2:1] == 2'h3)
        op_d = fpu_decode_pkg::OP_COMPARE; // RQ12
      else if (fclass == fpu_decode_pkg::FC_PAIRED && row == 3'h1)
        rsv_d = 1'b1; // RQ15
      else
        op_d = fpu_decode_pkg::OP_OTHER;
      // Long and paired-single need the 64-bit unit
      if ((fclass == fpu_decode_pkg::FC_LONG || fclass == fpu_decode_pkg::FC_PAIRED)
          && !fp64_enable)
        rsv_d = 1'b1; // RQ6 RQ7 RQ15
    end
    else if (fp_extension_group)
    begin
      unique case (row)
        3'h0:    op_d = fpu_decode_pkg::OP_IDX_LOAD_W;  // RQ10
        3'h1:    op_d = fpu_decode_pkg::OP_IDX_STORE_W; // RQ10
        3'h4:    op_d = fpu_decode_pkg::OP_FMADD_S;     // RQ11
        3'h5:    op_d = fpu_decode_pkg::OP_FMSUB_S;     // RQ11
        3'h6:    op_d = fpu_decode_pkg::OP_NFMADD_S;    // RQ11
        3'h7:    op_d = fpu_decode_pkg::OP_NFMSUB_S;    // RQ11
        default: rsv_d = 1'b1;                          // RQ11
      endcase
      // Three-bit format of fused ops cannot reach 24..31; only reserved 2,3 checked
      if (!fp64_enable)
        rsv_d = 1'b1; // RQ8 RQ15
      if (rsv_d)
        op_d = fpu_decode_pkg::OP_NONE;
    end
    else if (is_cop2)
    begin
      unique case (high_rs)
        2'h0:    op_d = fpu_decode_pkg::OP_MF_COP2;     // RQ13
        2'h1:    op_d = fpu_decode_pkg::OP_COP2_BRANCH; // RQ13
        default: op_d = fpu_decode_pkg::OP_OTHER;
      endcase
    end
    if (rsv_d)
      op_d = fpu_decode_pkg::OP_NONE;
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dec_valid_q <= 1'b0;
      fmt_class_q <= fpu_decode_pkg::FC_IFACE;
      fp_op_q     <= fpu_decode_pkg::OP_NONE;
      reserved_q  <= 1'b0;
    end
    else
    begin
      dec_valid_q <= insn_valid;
      fmt_class_q <= fclass;
      fp_op_q     <= insn_valid ? op_d : fpu_decode_pkg::OP_NONE;
      reserved_q  <= insn_valid & rsv_d;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  long_needs_64_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ6
    insn_valid && is_cop1 && fmt == fpu_decode_pkg::FMT_LONG && !fp64_enable
    |=> reserved_q)
    else $error("long format accepted with 64-bit disabled");
  paired_needs_64_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ7
    insn_valid && is_cop1 && fmt == fpu_decode_pkg::FMT_PAIRED && !fp64_enable
    |=> reserved_q && fp_op_q == fpu_decode_pkg::OP_NONE)
    else $error("paired format accepted with 64-bit disabled");
  ext_needs_64_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ8
    insn_valid && fp_extension_group && !fp64_enable |=> reserved_q)
    else $error("extension group accepted with 64-bit disabled");
  iface_class_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ1
    insn_valid && fmt < 5'h10 |=> fmt_class_q == fpu_decode_pkg::FC_IFACE)
    else $error("interface format misclassified");
  cmov_select_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ9
    insn_valid && is_cop1 && fmt == fpu_decode_pkg::FMT_SINGLE && func == 6'h11
    |=> fp_op_q == ($past(true_false_select_bit) ? fpu_decode_pkg::OP_MOVE_IF_T
                                                : fpu_decode_pkg::OP_MOVE_IF_F))
    else $error("conditional move variant wrong");
  arith_row_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ5
    insn_valid && is_cop1 && fmt == fpu_decode_pkg::FMT_DOUBLE && func == 6'h04
    |=> fp_op_q == fpu_decode_pkg::OP_SQRT)
    else $error("double square root not decoded");
  ext_load_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ10
    insn_valid && fp_extension_group && fp64_enable && row == 3'h0
    |=> fp_op_q == fpu_decode_pkg::OP_IDX_LOAD_W && !reserved_q)
    else $error("indexed load not decoded");
  reserved_fmt_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ4
    insn_valid && is_cop1 &&
    (fmt == 5'h12 || fmt == 5'h13 || fmt == 5'h17 || fmt >= 5'h18)
    |=> reserved_q && fp_op_q == fpu_decode_pkg::OP_NONE &&
        fmt_class_q == fpu_decode_pkg::FC_RESERVED)
    else $error("reserved format not flagged");
  cop2_branch_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ13
    insn_valid && is_cop2 && fmt[4:3] == 2'h1
    |=> fp_op_q == fpu_decode_pkg::OP_COP2_BRANCH)
    else $error("coprocessor-2 branch not decoded");
endmodule
`default_nettype wire

/* tb/fetch_model.sv */
/*
  Fetch stage model: hands one instruction word per cycle to the decoder.
  Assumes the bench calls its tasks; words change after the falling edge.
*/
`timescale 1ns/1ns
`default_nettype none
module fetch_model (
  input  wire logic        clk,        // Core clock
  output logic             insn_valid, // Word present
  output logic [31:0]      insn        // Instruction word
);
  // ----------------------------------------
  // Word issue
  // ----------------------------------------
  initial
  begin
    insn_valid = 1'b0;
    insn       = 32'h0;
  end
  task automatic issue(input logic [31:0] w);
    @(negedge clk);
    insn_valid <= 1'b1;
    insn       <= w;
  endtask
  // Idle word is inverted so a stale value cannot pass for a fresh one
  task automatic idle();
    @(negedge clk);
    insn_valid <= 1'b0;
    insn       <= ~insn;
  endtask
endmodule
`default_nettype wire

/* tb/fpu_format_function_decoder_test.sv */
/*
  Self-checking bench for the format and function decoder.
  Assumes a one-cycle registered answer and the fetch model as word source.
*/
`timescale 1ns/1ns
`default_nettype none
module test_fpu_format_function_decoder;
  logic                       clk = 1'b0;
  logic                       reset_n;
  logic                       fp64_enable;
  logic                       insn_valid;
  logic [31:0]                insn;
  logic                       dec_valid_q;
  fpu_decode_pkg::fmt_class_t fmt_class_q;
  fpu_decode_pkg::fp_op_t     fp_op_q;
  logic                       reserved_q;
  int                         n_errors = 0;
  int                         comparisons = 0;
  always #5 clk = ~clk;
  fetch_model i_fetch (.clk(clk), .insn_valid(insn_valid), .insn(insn));
  fpu_format_function_decoder i_dut (.clk(clk), .reset_n(reset_n), .insn_valid(insn_valid),
    .insn(insn), .fp64_enable(fp64_enable), .dec_valid_q(dec_valid_q),
    .fmt_class_q(fmt_class_q), .fp_op_q(fp_op_q), .reserved_q(reserved_q));
  // ----------------------------------------
  // Comparison and transfer helpers
  // ----------------------------------------
  task automatic compare_bit(input string nm, input logic e, input logic s);
    comparisons++;
    n_errors += int'(s !== e);
    if (s !== e)
      $display("MISMATCH %s expected %b seen %b", nm, e, s);
  endtask
  task automatic compare_class(input fpu_decode_pkg::fmt_class_t e);
    comparisons++;
    n_errors += int'(fmt_class_q !== e);
    if (fmt_class_q !== e)
      $display("MISMATCH fmt_class_q expected %h seen %h", e, fmt_class_q);
  endtask
  task automatic compare_op(input fpu_decode_pkg::fp_op_t e);
    comparisons++;
    n_errors += int'(fp_op_q !== e);
    if (fp_op_q !== e)
      $display("MISMATCH fp_op_q expected %h seen %h", e, fp_op_q);
  endtask
  function automatic logic [31:0] mk(input logic [5:0] o, input logic [4:0] f,
                                     input logic tf, input logic [5:0] fn);
    return {o, f, 4'h0, tf, 10'h000, fn};
  endfunction
  // Result is read 1 ns after the taking edge, so back-to-back words still fit
  task automatic put(input logic [31:0] w, input logic f, input fpu_decode_pkg::fmt_class_t c,
                     input fpu_decode_pkg::fp_op_t o, input logic r);
    i_fetch.issue(w);
    fp64_enable <= f;
    @(posedge clk);
    #1;
    compare_bit("dec_valid_q", 1'b1, dec_valid_q);
    compare_class(c);
    compare_op(o);
    compare_bit("reserved_q", r, reserved_q);
  endtask
  task automatic check_quiet();
    compare_bit("dec_valid_q", 1'b0, dec_valid_q);
    compare_op(fpu_decode_pkg::OP_NONE);
    compare_bit("reserved_q", 1'b0, reserved_q);
  endtask
  task automatic print_verdict();
    $display("n_errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_arith();
    logic [4:0] fm [4] = '{5'h10, 5'h11, 5'h14, 5'h15};
    for (int k = 0; k < 4; k++)
      for (int i = 0; i < 8; i++)
        put(mk(fpu_decode_pkg::OPC_COP1, fm[k], 1'b0, 6'(i)), 1'b1,
            fpu_decode_pkg::fmt_class_t'(k + 1), fpu_decode_pkg::fp_op_t'(i + 1), 1'b0);
    put(mk(fpu_decode_pkg::OPC_COP1, fm[3], 1'b0, 6'h00), 1'b0, fpu_decode_pkg::FC_LONG,
        fpu_decode_pkg::OP_NONE, 1'b1);
  endtask
  task automatic test_formats();
    for (int i = 0; i < 32; i++)
      if (i < 16)
        put(mk(fpu_decode_pkg::OPC_COP1, 5'(i), 1'b0, 6'h00), 1'b1, fpu_decode_pkg::FC_IFACE,
            i < 8 ? fpu_decode_pkg::fp_op_t'(i + 20) : fpu_decode_pkg::OP_OTHER, 1'b0);
      else if (i > 22 || i == 18 || i == 19)
        put(mk(fpu_decode_pkg::OPC_COP1, 5'(i), 1'b0, 6'h00), 1'b1,
            fpu_decode_pkg::FC_RESERVED, fpu_decode_pkg::OP_NONE, 1'b1);
  endtask
  task automatic test_paired();
    logic [5:0] fn [6] = '{6'h00, 6'h08, 6'h20, 6'h28, 6'h30, 6'h38};
    logic [4:0] op [6] = '{5'h01, 5'h00, 5'h0B, 5'h0C, 5'h0D, 5'h0D};
    for (int i = 0; i < 6; i++)
      put(mk(fpu_decode_pkg::OPC_COP1, 5'h16, 1'b0, fn[i]), 1'b1, fpu_decode_pkg::FC_PAIRED,
          fpu_decode_pkg::fp_op_t'(op[i]), i == 1);
    put(mk(fpu_decode_pkg::OPC_COP1, 5'h16, 1'b0, 6'h00), 1'b0, fpu_decode_pkg::FC_PAIRED,
        fpu_decode_pkg::OP_NONE, 1'b1);
  endtask
  task automatic test_cond_move();
    logic [4:0] fm [3] = '{5'h10, 5'h11, 5'h16};
    logic [3:0] cl [3] = '{4'h1, 4'h2, 4'h5};
    for (int i = 0; i < 6; i++)
      put(mk(fpu_decode_pkg::OPC_COP1, fm[i / 2], 1'(i), 6'h11), 1'b1,
          fpu_decode_pkg::fmt_class_t'(cl[i / 2]),
          fpu_decode_pkg::fp_op_t'(9 + i % 2), 1'b0);
  endtask
  task automatic test_ext();
    for (int r = 0; r < 8; r++)
      put(mk(fpu_decode_pkg::OPC_EXT, 5'h10, 1'b0, 6'(r * 8)), 1'b1, fpu_decode_pkg::FC_SINGLE,
          fpu_decode_pkg::fp_op_t'(r < 2 ? 14 + r : (r > 3 ? 12 + r : 0)),
          r == 2 || r == 3);
    put(mk(fpu_decode_pkg::OPC_EXT, 5'h10, 1'b0, 6'h00), 1'b0, fpu_decode_pkg::FC_SINGLE,
        fpu_decode_pkg::OP_NONE, 1'b1);
  endtask
  task automatic test_cop2();
    put(mk(fpu_decode_pkg::OPC_COP2, 5'h00, 1'b0, 6'h00), 1'b1, fpu_decode_pkg::FC_IFACE,
        fpu_decode_pkg::OP_MF_COP2, 1'b0);
    put(mk(fpu_decode_pkg::OPC_COP2, 5'h08, 1'b0, 6'h00), 1'b1, fpu_decode_pkg::FC_IFACE,
        fpu_decode_pkg::OP_COP2_BRANCH, 1'b0);
    put(mk(fpu_decode_pkg::OPC_COP2, 5'h18, 1'b0, 6'h00), 1'b1, fpu_decode_pkg::FC_RESERVED,
        fpu_decode_pkg::OP_OTHER, 1'b0);
    put(mk(6'h00, 5'h10, 1'b0, 6'h00), 1'b1, fpu_decode_pkg::FC_SINGLE,
        fpu_decode_pkg::OP_NONE, 1'b0);
  endtask
  // Reset lands while a word stays valid; that word is taken at the first edge after release
  task automatic test_idle_reset();
    i_fetch.idle();
    @(posedge clk);
    #1;
    check_quiet();
    i_fetch.issue(mk(fpu_decode_pkg::OPC_COP1, 5'h10, 1'b0, 6'h00));
    @(posedge clk);
    #1;
    compare_op(fpu_decode_pkg::OP_ADD);
    @(negedge clk);
    reset_n = 1'b0;
    #1;
    check_quiet();
    compare_class(fpu_decode_pkg::FC_IFACE);
    @(negedge clk);
    reset_n = 1'b1;
    @(posedge clk);
    #1;
    compare_bit("dec_valid_q", 1'b1, dec_valid_q);
    compare_class(fpu_decode_pkg::FC_SINGLE);
    compare_op(fpu_decode_pkg::OP_ADD);
  endtask
  initial
  begin
    #100000;
    n_errors++;
    print_verdict();
  end
  initial
  begin
    reset_n     = 1'b0;
    fp64_enable = 1'b0;
    repeat (20) @(negedge clk);
    check_quiet();
    reset_n = 1'b1;
    test_arith();
    test_formats();
    test_paired();
    test_cond_move();
    test_ext();
    test_cop2();
    test_idle_reset();
    test_cop2();
    print_verdict();
  end
endmodule
`default_nettype wire
